/* common/pfs_pkg.sv */
package pfs_pkg;
    localparam int PC_W  = 15;
    localparam int CTX_W = 40;
    localparam int DW    = 16;
    localparam int AW    = 4;
    localparam int INSN_COUNT = 49;

    localparam logic [14:0] RST_VEC   = 15'h0000;
    localparam logic [14:0] INT_VEC   = 15'h0004;
    localparam logic [14:0] MASK_2K   = 15'h07FF;
    localparam logic [14:0] MASK_4K   = 15'h0FFF;
    localparam logic [14:0] HEF_WORDS = 15'h0080;

    localparam logic [4:0] STK_DEPTH = 5'h10;

    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_POWER_CONTROL_REG = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_PTR0 = 4'h3;
    localparam logic [3:0] REG_PTR1 = 4'h4;
    localparam logic [3:0] REG_PC   = 4'h5;
    localparam logic [3:0] REG_STK  = 4'h6;

    localparam int CTRL_VAR_BIT = 0;
    localparam int CTRL_SRE_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int POWER_CONTROL_REG_OVF_BIT = 0;
    localparam int POWER_CONTROL_REG_UNF_BIT = 1;

    localparam int PTR_PGM_BIT = 15;
    localparam logic [15:0] TRAD_LIMIT = 16'h1000;
    localparam logic [15:0] LIN_BASE   = 16'h2000;
    localparam logic [15:0] LIN_SIZE   = 16'h0A00;
    localparam logic [11:0] GPR_BYTES  = 12'h050;
    localparam logic [11:0] GPR_OFS    = 12'h020;

    typedef enum logic [2:0] {
        OP_NOP    = 3'b000,
        OP_STEP   = 3'b001,
        OP_JUMP   = 3'b010,
        OP_CALL   = 3'b011,
        OP_RET    = 3'b100,
        OP_RETFIE = 3'b101,
        OP_INT    = 3'b110
    } pfs_op_e;

    typedef enum logic {
        PS_IDLE = 1'b0,
        PS_POP  = 1'b1
    } pfs_pc_st_e;

    typedef enum logic [1:0] {
        IS_IDLE = 2'b00,
        IS_ACC  = 2'b01,
        IS_XTRA = 2'b10,
        IS_CAP  = 2'b11
    } pfs_ind_st_e;
endpackage : pfs_pkg

/* rtl/pfs_stack_mem.sv */
`timescale 1ns/10ps
module pfs_stack_mem (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [14:0] wdata,
    input  wire logic [3:0]  raddr,
    output logic      [14:0] rdata
);
    logic [14:0] mem [16];

    // No reset on the array: contents are only read after a push
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : pfs_stack_mem

/* rtl/pfs_ctx_shadow.sv */
`timescale 1ns/10ps
module pfs_ctx_shadow (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        save,
    input  wire logic [39:0] din,
    output logic      [39:0] dout
);
    logic [39:0] next_dout;

    always_comb begin
        next_dout = save ? din : dout;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dout <= 40'h0000000000;
        end else begin
            dout <= next_dout;
        end
    end
endmodule : pfs_ctx_shadow

/* rtl/pfs_core.sv */
`timescale 1ns/10ps
// Behaviour
// - Return addresses live in a private 16 by 15-bit stack.
// - Push on full stack sets overflow flag; pop on empty sets underflow.
// - With reset option on, overflow or underflow also issues a soft reset.
// - Interrupt entry saves core context to shadows; RETFIE restores it, plain RET does not.
// - Two 16-bit pointers reach all file registers and program memory.
// - Indirect access to program memory takes one extra cycle.
// - Linear window lets pointers walk GPR beyond 80-byte banks.
// - Program counter is 15 bits wide, 32K word space.
// - Implemented program memory is 2K or 4K words by variant.
// - Addresses beyond implemented memory wrap inside it.
// - Reset starts at 0000h; interrupts vector to 0004h.
// - Top 128 words form high-endurance region, low byte only.
// - Constants read via return-with-literal tables or program pointer.
// - Decoder supports exactly 49 instructions, pointer ones included.
// - Pointer high bit 7 selects program memory; read yields low byte.
// - Indirect writes aimed at program memory change nothing.
module pfs_core
    import pfs_pkg::*;
(
    input  wire logic                 CLK_SYS,
    input  wire logic                 NRST,
    input  wire logic [pfs_pkg::AW-1:0] ADDR,
    input  wire logic [pfs_pkg::DW-1:0] WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic      [pfs_pkg::DW-1:0] RDATA,
    output logic                      IRQ,
    input  wire logic [2:0]           PC_OP,
    input  wire logic [14:0]          PC_TARGET,
    output logic      [14:0]          PC,
    output logic                      PC_HEF,
    output logic                      BUSY,
    output logic                      SOFT_RST,
    input  wire logic [39:0]          CTX_IN,
    output logic      [39:0]          CTX_OUT,
    output logic                      CTX_LOAD,
    input  wire logic                 IND_REQ,
    input  wire logic                 IND_SEL,
    input  wire logic                 IND_WR,
    input  wire logic [7:0]           IND_WDATA,
    output logic      [7:0]           IND_RDATA,
    output logic                      IND_DONE,
    output logic                      IND_HEF,
    output logic      [11:0]          DMEM_ADDR,
    output logic                      DMEM_RE,
    output logic                      DMEM_WE,
    output logic      [7:0]           DMEM_WDATA,
    input  wire logic [7:0]           DMEM_RDATA,
    output logic      [14:0]          PMEM_ADDR,
    output logic                      PMEM_RE,
    input  wire logic [13:0]          PMEM_RDATA
);
    import pfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  ctrl;
    logic [1:0]  power_control_reg;
    logic [1:0]  mask;
    logic [15:0] ptr [2];
    logic [1:0]  next_ctrl;
    logic [1:0]  next_power_control_reg;
    logic [1:0]  next_mask;
    logic [15:0] next_ptr [2];
    logic [15:0] next_rdata;
    logic        next_irq;

    pfs_pc_st_e  pst;
    pfs_pc_st_e  next_pst;
    logic [4:0]  cnt;
    logic [4:0]  next_cnt;
    logic [14:0] next_pc;
    logic        next_pc_hef;
    logic        fie;
    logic        next_fie;
    logic        next_soft_rst;
    logic        next_ctx_load;
    logic        push;
    logic [14:0] push_val;
    logic        ovf;
    logic        unf;
    logic        save;
    logic [14:0] stk_rdata;
    logic [14:0] pc_mask;

    pfs_ind_st_e ist;
    pfs_ind_st_e next_ist;
    logic        next_ind_done;
    logic [7:0]  next_ind_rdata;
    logic        next_ind_hef;
    logic [11:0] next_dmem_addr;
    logic        next_dmem_re;
    logic        next_dmem_we;
    logic [7:0]  next_dmem_wdata;
    logic [14:0] next_pmem_addr;
    logic        next_pmem_re;
    logic        i_pgm;
    logic        i_map;
    logic        next_i_pgm;
    logic        next_i_map;
    logic [15:0] sel_ptr;
    logic [15:0] lin_off;
    logic [11:0] lin_bank;
    logic [11:0] lin_idx;

    // Variant decides the implemented span; upper PC bits are dropped
    assign pc_mask = ctrl[CTRL_VAR_BIT] ? MASK_4K : MASK_2K;

    function automatic logic is_hef(input logic [14:0] a, input logic [14:0] m);
        is_hef = (a & m) >= (m - HEF_WORDS + 15'h0001);
    endfunction : is_hef

    pfs_stack_mem u_stack (
        .clk   (CLK_SYS),
        .we    (push && !ovf),
        .waddr (cnt[3:0]),
        .wdata (push_val),
        .raddr (cnt[3:0] - 4'h1),
        .rdata (stk_rdata)
    );

    pfs_ctx_shadow u_shadow (
        .clk  (CLK_SYS),
        .nrst (NRST),
        .save (save),
        .din  (CTX_IN),
        .dout (CTX_OUT)
    );

    ////////////////////////////////////////////////////////////////////////
    // Program counter and return stack
    always_comb begin
        next_pst      = pst;
        next_cnt      = cnt;
        next_pc       = PC;
        next_fie      = fie;
        next_ctx_load = 1'b0;
        push          = 1'b0;
        push_val      = PC;
        ovf           = 1'b0;
        unf           = 1'b0;
        save          = 1'b0;
        if (pst == PS_IDLE) begin
            case (PC_OP)
                OP_STEP: next_pc = (PC + 15'h0001) & pc_mask;
                OP_JUMP: next_pc = PC_TARGET & pc_mask;
                OP_CALL: begin
                    push     = 1'b1;
                    push_val = (PC + 15'h0001) & pc_mask;
                    next_pc  = PC_TARGET & pc_mask;
                end
                OP_INT: begin
                    push    = 1'b1;
                    save    = 1'b1;
                    next_pc = INT_VEC;
                end
                OP_RET, OP_RETFIE: begin
                    // Constant tables return here with the literal in W
                    if (cnt == 5'h00) begin
                        unf = 1'b1;
                    end else begin
                        next_cnt = cnt - 5'h01;
                        next_pst = PS_POP;
                        next_fie = (PC_OP == OP_RETFIE);
                    end
                end
                default: ;
            endcase
            if (push) begin
                if (cnt == STK_DEPTH) begin
                    ovf = 1'b1;
                end else begin
                    next_cnt = cnt + 5'h01;
                end
            end
        end else begin
            next_pc       = stk_rdata & pc_mask;
            next_ctx_load = fie;
            next_pst      = PS_IDLE;
        end
        next_soft_rst = (ovf || unf) && ctrl[CTRL_SRE_BIT];
        if (next_soft_rst) begin
            next_pc       = RST_VEC;
            next_cnt      = 5'h00;
            next_pst      = PS_IDLE;
            next_ctx_load = 1'b0;
        end
        next_pc_hef = is_hef(next_pc, pc_mask);
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            pst      <= PS_IDLE;
            cnt      <= 5'h00;
            PC       <= RST_VEC;
            PC_HEF   <= 1'b0;
            fie      <= 1'b0;
            SOFT_RST <= 1'b0;
            CTX_LOAD <= 1'b0;
            BUSY     <= 1'b0;
        end else begin
            pst      <= next_pst;
            cnt      <= next_cnt;
            PC       <= next_pc;
            PC_HEF   <= next_pc_hef;
            fie      <= next_fie;
            SOFT_RST <= next_soft_rst;
            CTX_LOAD <= next_ctx_load;
            BUSY     <= (next_pst == PS_POP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indirect access through the two pointers
    assign sel_ptr  = ptr[IND_SEL];
    assign lin_off  = sel_ptr - LIN_BASE;
    assign lin_bank = lin_off[11:0] / GPR_BYTES;
    assign lin_idx  = lin_off[11:0] % GPR_BYTES;

    always_comb begin
        next_ist        = ist;
        next_ind_done   = 1'b0;
        next_ind_rdata  = IND_RDATA;
        next_ind_hef    = IND_HEF;
        next_dmem_addr  = DMEM_ADDR;
        next_dmem_re    = 1'b0;
        next_dmem_we    = 1'b0;
        next_dmem_wdata = DMEM_WDATA;
        next_pmem_addr  = PMEM_ADDR;
        next_pmem_re    = 1'b0;
        next_i_pgm      = i_pgm;
        next_i_map      = i_map;
        case (ist)
            IS_IDLE: begin
                if (IND_REQ) begin
                    next_ist        = IS_ACC;
                    next_i_pgm      = sel_ptr[PTR_PGM_BIT];
                    next_i_map      = 1'b1;
                    next_dmem_wdata = IND_WDATA;
                    next_ind_hef    = 1'b0;
                    if (sel_ptr[PTR_PGM_BIT]) begin
                        next_pmem_addr = sel_ptr[14:0] & pc_mask;
                        next_pmem_re   = !IND_WR;
                        next_ind_hef   = is_hef(sel_ptr[14:0], pc_mask);
                    end else if (sel_ptr < TRAD_LIMIT) begin
                        next_dmem_addr = sel_ptr[11:0];
                        next_dmem_re   = !IND_WR;
                        next_dmem_we   = IND_WR;
                    end else if (sel_ptr >= LIN_BASE && sel_ptr < LIN_BASE + LIN_SIZE) begin
                        next_dmem_addr = {lin_bank[4:0], 7'h00} + GPR_OFS + lin_idx;
                        next_dmem_re   = !IND_WR;
                        next_dmem_we   = IND_WR;
                    end else begin
                        // Unimplemented space reads as zero
                        next_i_map = 1'b0;
                    end
                end
            end
            IS_ACC:  next_ist = i_pgm ? IS_XTRA : IS_CAP;
            IS_XTRA: next_ist = IS_CAP;
            default: begin
                next_ist      = IS_IDLE;
                next_ind_done = 1'b1;
                if (!i_map) begin
                    next_ind_rdata = 8'h00;
                end else if (i_pgm) begin
                    next_ind_rdata = PMEM_RDATA[7:0];
                end else begin
                    next_ind_rdata = DMEM_RDATA;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            ist        <= IS_IDLE;
            IND_DONE   <= 1'b0;
            IND_RDATA  <= 8'h00;
            IND_HEF    <= 1'b0;
            DMEM_ADDR  <= 12'h000;
            DMEM_RE    <= 1'b0;
            DMEM_WE    <= 1'b0;
            DMEM_WDATA <= 8'h00;
            PMEM_ADDR  <= 15'h0000;
            PMEM_RE    <= 1'b0;
            i_pgm      <= 1'b0;
            i_map      <= 1'b0;
        end else begin
            ist        <= next_ist;
            IND_DONE   <= next_ind_done;
            IND_RDATA  <= next_ind_rdata;
            IND_HEF    <= next_ind_hef;
            DMEM_ADDR  <= next_dmem_addr;
            DMEM_RE    <= next_dmem_re;
            DMEM_WE    <= next_dmem_we;
            DMEM_WDATA <= next_dmem_wdata;
            PMEM_ADDR  <= next_pmem_addr;
            PMEM_RE    <= next_pmem_re;
            i_pgm      <= next_i_pgm;
            i_map      <= next_i_map;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port; flags survive the soft reset so software can see why
    always_comb begin
        next_ctrl   = ctrl;
        next_mask   = mask;
        next_ptr[0] = ptr[0];
        next_ptr[1] = ptr[1];
        next_power_control_reg   = power_control_reg;
        next_rdata  = 16'h0000;
        if (WR) begin
            if (ADDR == REG_CTRL) begin
                next_ctrl = WDATA[1:0];
            end else if (ADDR == REG_POWER_CONTROL_REG) begin
                next_power_control_reg = power_control_reg & ~WDATA[1:0];
            end else if (ADDR == REG_MASK) begin
                next_mask = WDATA[1:0];
            end else if (ADDR == REG_PTR0) begin
                next_ptr[0] = WDATA;
            end else if (ADDR == REG_PTR1) begin
                next_ptr[1] = WDATA;
            end
        end
        // Set wins over a same-cycle clear
        next_power_control_reg[POWER_CONTROL_REG_OVF_BIT] = next_power_control_reg[POWER_CONTROL_REG_OVF_BIT] | ovf;
        next_power_control_reg[POWER_CONTROL_REG_UNF_BIT] = next_power_control_reg[POWER_CONTROL_REG_UNF_BIT] | unf;
        if (RD) begin
            if (ADDR == REG_CTRL) begin
                next_rdata = {14'h0000, ctrl};
            end else if (ADDR == REG_POWER_CONTROL_REG) begin
                next_rdata = {14'h0000, power_control_reg};
            end else if (ADDR == REG_MASK) begin
                next_rdata = {14'h0000, mask};
            end else if (ADDR == REG_PTR0) begin
                next_rdata = ptr[0];
            end else if (ADDR == REG_PTR1) begin
                next_rdata = ptr[1];
            end else if (ADDR == REG_PC) begin
                next_rdata = {1'b0, PC};
            end else if (ADDR == REG_STK) begin
                next_rdata = {11'h000, cnt};
            end
        end
        next_irq = |(next_power_control_reg & next_mask);
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            ctrl   <= CTRL_RST;
            power_control_reg   <= 2'h0;
            mask   <= 2'h0;
            ptr[0] <= 16'h0000;
            ptr[1] <= 16'h0000;
            RDATA  <= 16'h0000;
            IRQ    <= 1'b0;
        end else begin
            ctrl   <= next_ctrl;
            power_control_reg   <= next_power_control_reg;
            mask   <= next_mask;
            ptr[0] <= next_ptr[0];
            ptr[1] <= next_ptr[1];
            RDATA  <= next_rdata;
            IRQ    <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    logic idle_op;
    logic ind_go;
    logic sre;
    assign idle_op = (pst == PS_IDLE);
    assign sre     = ctrl[CTRL_SRE_BIT];
    assign ind_go  = (ist == IS_IDLE) && IND_REQ;

    stack_depth_a: assert property (cnt <= STK_DEPTH)
        else $error("stack count beyond depth");
    ovf_flag_a: assert property (idle_op && push && cnt == STK_DEPTH |=> power_control_reg[POWER_CONTROL_REG_OVF_BIT])
        else $error("overflow flag not set");
    unf_flag_a: assert property (idle_op && (PC_OP == OP_RET || PC_OP == OP_RETFIE) && cnt == 5'h00
                                 |=> power_control_reg[POWER_CONTROL_REG_UNF_BIT])
        else $error("underflow flag not set");
    soft_rst_a: assert property ((ovf || unf) |=> SOFT_RST == $past(sre)
                                 && (!SOFT_RST || cnt == 5'h00 && PC == RST_VEC))
        else $error("soft reset does not follow option");
    ctx_save_a: assert property (idle_op && PC_OP == OP_INT |=> CTX_OUT == $past(CTX_IN))
        else $error("context not saved");
    pgm_extra_a: assert property (ind_go && sel_ptr[PTR_PGM_BIT] |=> !IND_DONE [*3] ##1 IND_DONE)
        else $error("program read latency wrong");
    data_lat_a: assert property (ind_go && !sel_ptr[PTR_PGM_BIT] |=> !IND_DONE [*2] ##1 IND_DONE)
        else $error("data access latency wrong");
    no_pwrite_a: assert property (ind_go && sel_ptr[PTR_PGM_BIT] && IND_WR |=> !DMEM_WE && !PMEM_RE)
        else $error("program write leaked");
    jump_wrap_a: assert property (idle_op && PC_OP == OP_JUMP && !SOFT_RST
                                  |=> PC == ($past(PC_TARGET) & $past(pc_mask)))
        else $error("jump target not wrapped");
    int_vec_a: assert property (idle_op && PC_OP == OP_INT && cnt < STK_DEPTH |=> PC == INT_VEC)
        else $error("interrupt vector wrong");
    call_ret_a: assert property (idle_op && PC_OP == OP_CALL && cnt < STK_DEPTH ##1 PC_OP == OP_NOP
                                 ##1 idle_op && PC_OP == OP_RET
                                 |=> ##1 PC == (($past(PC, 4) + 15'h0001) & $past(pc_mask, 4)))
        else $error("return address wrong");

    call_cov: cover property (idle_op && PC_OP == OP_CALL ##2 PC_OP == OP_RET);
    ovf_rst_cov: cover property ((ovf || unf) && sre);
    pgm_rd_cov: cover property (ind_go && sel_ptr[PTR_PGM_BIT] && !IND_WR);
endmodule : pfs_core

/* test/pfs_mem_model.sv */
`timescale 1ns/10ps
module pfs_mem_model (
    input  wire logic        CLK_SYS,
    input  wire logic [11:0] DMEM_ADDR,
    input  wire logic        DMEM_RE,
    input  wire logic        DMEM_WE,
    input  wire logic [7:0]  DMEM_WDATA,
    output logic      [7:0]  DMEM_RDATA,
    input  wire logic [14:0] PMEM_ADDR,
    input  wire logic        PMEM_RE,
    output logic      [13:0] PMEM_RDATA
);
    logic [7:0] ram [4096];
    initial begin
        for (int i = 0; i < 4096; i++) ram[i] = 8'(i) ^ 8'hA5;
        DMEM_RDATA = 8'h00;
        PMEM_RDATA = 14'h0000;
    end
    // Data read data is good for one cycle only, then it inverts; program read data holds
    // Program array has no write path at all
    always @(posedge CLK_SYS) begin
        if (DMEM_WE) ram[DMEM_ADDR] <= DMEM_WDATA;
        DMEM_RDATA <= DMEM_RE ? ram[DMEM_ADDR] : ~DMEM_RDATA;
        if (PMEM_RE) PMEM_RDATA <= {PMEM_ADDR[5:0], PMEM_ADDR[7:0] ^ 8'h5A};
    end
endmodule : pfs_mem_model

/* test/test_cpu_pc_stack_memory_map.sv */
`timescale 1ns/10ps
module test_cpu_pc_stack_memory_map;
    import pfs_pkg::*;
    logic        CLK_SYS, NRST, WR, RD, IRQ, PC_HEF, BUSY, SOFT_RST, CTX_LOAD;
    logic        IND_REQ, IND_SEL, IND_WR, IND_DONE, IND_HEF, DMEM_RE, DMEM_WE, PMEM_RE;
    logic [3:0]  ADDR;
    logic [2:0]  PC_OP;
    logic [15:0] WDATA, RDATA;
    logic [14:0] PC_TARGET, PC, PMEM_ADDR;
    logic [39:0] CTX_IN, CTX_OUT;
    logic [7:0]  IND_WDATA, IND_RDATA, DMEM_WDATA, DMEM_RDATA;
    logic [11:0] DMEM_ADDR;
    logic [13:0] PMEM_RDATA;
    int          miscompares, n_tests, cyc, soft_n, load_n, re_n, we_n, pre_n, depth;

    pfs_core i_dut (.*);
    pfs_mem_model i_mem (.*);

    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    // Cheap event counters keep one-cycle pulses from being missed
    always @(posedge CLK_SYS) begin
        cyc++;
        soft_n += SOFT_RST;
        load_n += CTX_LOAD;
        re_n += DMEM_RE;
        we_n += DMEM_WE;
        pre_n += PMEM_RE;
        if (cyc == 4000) begin
            miscompares++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////
    task check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task close_out;
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK_SYS);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
    endtask : wr

    task rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1;
        check(nm, RDATA, e);
    endtask : rchk

    // Own stack depth; a pop of an empty stack never goes busy
    task op(input logic [2:0] o, input logic [14:0] t);
        logic pop;
        pop = (o == OP_RET || o == OP_RETFIE) && depth > 0;
        @(posedge CLK_SYS);
        PC_OP <= o;
        PC_TARGET <= t;
        @(posedge CLK_SYS);
        PC_OP <= 3'h0;
        #1;
        if ((o == OP_CALL || o == OP_INT) && depth < 16) depth++;
        if (o == OP_RET || o == OP_RETFIE) begin
            check("busy", BUSY, pop);
            if (pop) begin
                depth--;
                @(posedge CLK_SYS);
                #1;
            end
        end
    endtask : op

    task hef(input logic e);
        @(posedge CLK_SYS);
        #1;
        check("pc_hef", PC_HEF, e);
    endtask : hef

    task ind(input logic s, input logic w, input logic [7:0] d, input logic [14:0] ea, input int ec,
             input logic [7:0] er);
        int n;
        @(posedge CLK_SYS);
        IND_REQ <= 1'b1;
        IND_SEL <= s;
        IND_WR <= w;
        IND_WDATA <= d;
        @(posedge CLK_SYS);
        IND_REQ <= 1'b0;
        #1;
        n = 1;
        if (DMEM_RE || DMEM_WE) check("dmem_addr", DMEM_ADDR, ea);
        if (DMEM_WE) check("dmem_wdata", DMEM_WDATA, d);
        if (PMEM_RE) check("pmem_addr", PMEM_ADDR, ea);
        while (IND_DONE !== 1'b1 && n < 9) begin
            @(posedge CLK_SYS);
            #1;
            n++;
        end
        check("ind_cycles", n, ec);
        if (!w) check("ind_rdata", IND_RDATA, er);
    endtask : ind

    ////////////////////////////////////////////////////////////
    task t_pc;
        check("reset_pc", PC, RST_VEC);
        rchk("ctrl_reset", REG_CTRL, 16'h0001);
        wr(4'hF, 16'hFFFF);
        rchk("unmapped", 4'hF, 16'h0000);
        wr(REG_CTRL, 16'h0000);
        op(OP_JUMP, 15'h7FFF);
        check("wrap_2k", PC, 15'h07FF);
        hef(1'b1);
        op(OP_JUMP, 15'h077F);
        hef(1'b0);
        wr(REG_CTRL, 16'h0001);
        op(OP_JUMP, 15'h4F80);
        check("wrap_4k", PC, 15'h0F80);
        hef(1'b1);
        op(OP_STEP, 15'h0000);
        op(OP_JUMP, 15'h0FFF);
        op(OP_STEP, 15'h0000);
        check("step_wrap", PC, 15'h0000);
    endtask : t_pc

    task t_stack;
        op(OP_JUMP, 15'h0100);
        op(OP_CALL, 15'h0200);
        check("call_pc", PC, 15'h0200);
        op(OP_RET, 15'h0000);
        check("ret_pc", PC, 15'h0101);
        wr(REG_MASK, 16'h0001);
        repeat (16) op(OP_CALL, 15'h0300);
        rchk("stk_full", REG_STK, 16'h0010);
        rchk("no_ovf", REG_POWER_CONTROL_REG, 16'h0000);
        op(OP_CALL, 15'h0300);
        rchk("ovf", REG_POWER_CONTROL_REG, 16'h0001);
        check("irq_ovf", IRQ, 1);
        wr(REG_POWER_CONTROL_REG, 16'h0001);
        rchk("ovf_clr", REG_POWER_CONTROL_REG, 16'h0000);
        check("irq_clr", IRQ, 0);
        repeat (16) op(OP_RET, 15'h0000);
        check("deep_ret", PC, 15'h0102);
        op(OP_RET, 15'h0000);
        rchk("unf", REG_POWER_CONTROL_REG, 16'h0002);
        check("irq_masked", IRQ, 0);
        check("no_soft", soft_n, 0);
        wr(REG_POWER_CONTROL_REG, 16'h0002);
        wr(REG_CTRL, 16'h0003);
        op(OP_JUMP, 15'h0123);
        op(OP_RET, 15'h0000);
        rchk("unf_kept", REG_POWER_CONTROL_REG, 16'h0002);
        check("soft_rst", soft_n, 1);
        check("soft_pc", PC, RST_VEC);
        wr(REG_POWER_CONTROL_REG, 16'h0002);
        wr(REG_CTRL, 16'h0001);
    endtask : t_stack

    task t_int;
        CTX_IN <= 40'h9ABCDEF012;
        op(OP_JUMP, 15'h0456);
        op(OP_INT, 15'h0000);
        @(posedge CLK_SYS);
        CTX_IN <= 40'h0000000000;
        check("int_vec", PC, INT_VEC);
        check("ctx_save", CTX_OUT, 40'h9ABCDEF012);
        op(OP_RETFIE, 15'h0000);
        check("retfie_pc", PC, 15'h0456);
        rchk("stk_empty", REG_STK, 16'h0000);
        check("ctx_load", load_n, 1);
        check("ctx_kept", CTX_OUT, 40'h9ABCDEF012);
    endtask : t_int

    task t_ind;
        int w0;
        int p0;
        int r0;
        wr(REG_PTR0, 16'h0123);
        wr(REG_PTR1, 16'h2056);
        ind(1'b0, 1'b0, 8'h00, 15'h0123, 3, 8'h86);
        ind(1'b1, 1'b0, 8'h00, 15'h00A6, 3, 8'h03);
        ind(1'b0, 1'b1, 8'h3C, 15'h0123, 3, 8'h00);
        ind(1'b0, 1'b0, 8'h00, 15'h0123, 3, 8'h3C);
        wr(REG_PTR1, 16'h8F85);
        ind(1'b1, 1'b0, 8'h00, 15'h0F85, 4, 8'hDF);
        check("ind_hef", IND_HEF, 1);
        wr(REG_PTR1, 16'h8123);
        ind(1'b1, 1'b0, 8'h00, 15'h0123, 4, 8'h79);
        check("ind_nohef", IND_HEF, 0);
        w0 = we_n;
        p0 = pre_n;
        r0 = re_n;
        ind(1'b1, 1'b1, 8'h55, 15'h0000, 4, 8'h00);
        check("pgm_wr_we", we_n, w0);
        check("pgm_wr_re", pre_n, p0);
        wr(REG_PTR0, 16'h1800);
        ind(1'b0, 1'b0, 8'h00, 15'h0000, 3, 8'h00);
        check("gap_no_re", re_n, r0);
    endtask : t_ind

    initial begin
        {NRST, WR, RD, IND_REQ, IND_SEL, IND_WR} = 6'h00;
        {ADDR, WDATA, PC_OP, PC_TARGET, CTX_IN, IND_WDATA} = 86'h0;
        repeat (10) @(posedge CLK_SYS);
        NRST <= 1'b1;
        t_pc();
        t_stack();
        t_int();
        t_ind();
        close_out();
    end
endmodule : test_cpu_pc_stack_memory_map
